/* File: design/hbs_map.svh */
// Constants for the hibernation and boot sequencer.
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH
`define HBS_OTP_BYTES  768
`define HBS_OTP_AW     10
`define HBS_WAKE_W     16
`define HBS_CFG_N      3
`define HBS_ADDR_TRIM  10'h000
`define HBS_ADDR_PKG   10'h001
`define HBS_ADDR_MSIZE 10'h002
`define HBS_SY_REGON   0
`define HBS_SY_WAKE    1
`define HBS_SY_CORE    2
`define HBS_SY_IO      3
`define HBS_SY_XTAL    4
`define HBS_SY_SLOW    5
`define HBS_SY_N       6
`endif

/* File: design/hbs_otp_mem.sv */
// One-time programmable byte store with registered read data.
`timescale 1ns/100ps
`include "hbs_map.svh"
module hbs_otp_mem #(
	parameter int DEPTH = `HBS_OTP_BYTES
) (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   rd_en,
	input  wire logic                   wr_en,
	input  wire logic [`HBS_OTP_AW-1:0] addr,
	input  wire logic [7:0]             wdata,
	output logic      [7:0]             rdata,
	output logic                        rd_valid
);
	logic [7:0]     fuse [DEPTH];
	hbs_pkg::hbs_mem_s s_r;
	hbs_pkg::hbs_mem_s s_nxt;

	// blank fuses
	// The fuse array is not touched by reset, so content survives every reset.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			fuse[i] = 8'h00;
		end
	end

	// set only
	// Programming ORs the new byte in, so a fuse at one can never drop back.
	always_ff @(posedge clock) begin
		if (wr_en && (int'(addr) < DEPTH)) begin
			fuse[addr] <= fuse[addr] | wdata;
		end
	end

	// read path
	// Read data comes one cycle after the strobe; out-of-range bytes read zero.
	always_comb begin
		s_nxt     = s_r;
		s_nxt.vld = rd_en;
		if (rd_en) begin
			s_nxt.dat = (int'(addr) < DEPTH) ? fuse[addr] : 8'h00;
		end
	end

	// State register.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata    = s_r.dat;
	assign rd_valid = s_r.vld;

	chk_fuse_sticky: assert property (@(posedge clock) disable iff (!resetn)
		wr_en && (int'(addr) < DEPTH) |=> ((fuse[$past(addr)] & $past(fuse[addr]))
		== $past(fuse[addr])))
		else $error("fuse bit went back to zero");
endmodule // hbs_otp_mem

/* File: design/hbs_pkg.sv */
// Types shared by the hibernation and boot sequencer modules.
`include "hbs_map.svh"
package hbs_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_SETTLE, ST_CFG, ST_CORES, ST_XTAL, ST_RUN} hbs_state_e;
	typedef struct packed {
		hbs_state_e                 st;
		logic [`HBS_SY_N-1:0]       sy_a;
		logic [`HBS_SY_N-1:0]       sy_b;
		logic [`HBS_SY_N-1:0]       sy_c;
		logic [`HBS_SY_N-1:0]       lv;
		logic [1:0]                 cfg_i;
		logic                       cfg_wait;
		logic [7:0]                 trim;
		logic [7:0]                 pkg;
		logic [7:0]                 msize;
	} hbs_seq_s;
	typedef struct packed {
		logic                   pend;
		logic                   run;
		logic [`HBS_WAKE_W-1:0] load;
		logic [`HBS_WAKE_W-1:0] cnt;
	} hbs_tmr_s;
	typedef struct packed {
		logic       vld;
		logic [7:0] dat;
	} hbs_mem_s;
endpackage

/* File: design/hbs_sequencer.sv */
// Power-up sequencer with hibernation control and fuse configuration.
`timescale 1ns/100ps
`include "hbs_map.svh"
module hbs_sequencer (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   slow_clk_in,
	input  wire logic                   reg_on_in,
	input  wire logic                   hib_wake_in,
	input  wire logic                   core_regulator_ok,
	input  wire logic                   io_regulator_ok,
	input  wire logic                   xtal_ok,
	input  wire logic                   hib_request,
	input  wire logic [`HBS_WAKE_W-1:0] hib_wake_count,
	output logic                        hib_busy,
	output logic                        hib_power_enable_out,
	input  wire logic                   otp_rd_req,
	input  wire logic                   otp_wr_req,
	input  wire logic [`HBS_OTP_AW-1:0] otp_addr,
	input  wire logic [7:0]             otp_wdata,
	output logic                        otp_ready,
	output logic [7:0]                  otp_rdata,
	output logic                        otp_rd_valid,
	output logic [7:0]                  pmu_trim,
	output logic [7:0]                  package_sel,
	output logic [7:0]                  mem_size_sel,
	output logic                        app_core_power_en,
	output logic                        wlan_core_power_en,
	output logic                        xtal_power_en,
	output logic                        app_cpu_run,
	output logic                        wlan_cpu_run
);
	hbs_pkg::hbs_seq_s s_r;
	hbs_pkg::hbs_seq_s s_nxt;

	logic                   slow_tick;
	logic                   tmr_start;
	logic                   tmr_busy;
	logic                   tmr_pwr;
	logic                   mem_rd;
	logic                   mem_wr;
	logic [`HBS_OTP_AW-1:0] mem_addr;
	logic                   mem_vld;
	logic [7:0]             mem_dat;
	logic                   start_cond;

	// Filtered level: a change counts only once second and third stages agree.
	function automatic logic [`HBS_SY_N-1:0] agree(
		input logic [`HBS_SY_N-1:0] b,
		input logic [`HBS_SY_N-1:0] c,
		input logic [`HBS_SY_N-1:0] old
	);
		return (b & c) | (old & (b | c));
	endfunction

	// Fuse address of each configuration byte, in read order.
	function automatic logic [`HBS_OTP_AW-1:0] cfg_addr(input logic [1:0] i);
		case (i)
			2'h0: return `HBS_ADDR_TRIM;
			2'h1: return `HBS_ADDR_PKG;
			default: return `HBS_ADDR_MSIZE;
		endcase
	endfunction

	// Pins and the slow clock all pass three stages before use.
	logic [`HBS_SY_N-1:0] pins;
	assign pins[`HBS_SY_REGON] = reg_on_in;
	assign pins[`HBS_SY_WAKE]  = hib_wake_in;
	assign pins[`HBS_SY_CORE]  = core_regulator_ok;
	assign pins[`HBS_SY_IO]    = io_regulator_ok;
	assign pins[`HBS_SY_XTAL]  = xtal_ok;
	assign pins[`HBS_SY_SLOW]  = slow_clk_in;

	// A slow-clock rising edge seen through the filter, one cycle long.
	assign slow_tick = s_nxt.lv[`HBS_SY_SLOW] & !s_r.lv[`HBS_SY_SLOW];

	// software order
	// The count is taken together with the request, so it must already be stable.
	// busy ignores
	assign tmr_start = hib_request & (s_r.st == hbs_pkg::ST_RUN) & !tmr_busy;

	assign start_cond = (s_r.lv[`HBS_SY_REGON] | s_r.lv[`HBS_SY_WAKE]) & tmr_pwr;

	// Fuse port belongs to the sequencer while configuring, to software in the run step.
	always_comb begin
		mem_rd   = 1'b0;
		mem_wr   = 1'b0;
		mem_addr = otp_addr;
		if (s_r.st == hbs_pkg::ST_CFG) begin
			mem_rd   = !s_r.cfg_wait;
			mem_addr = cfg_addr(s_r.cfg_i);
		end else if (s_r.st == hbs_pkg::ST_RUN) begin
			mem_rd = otp_rd_req;
			mem_wr = otp_wr_req & !otp_rd_req;
		end
	end

	// Next state of the whole sequencer.
	always_comb begin
		s_nxt      = s_r;
		s_nxt.sy_a = pins;
		s_nxt.sy_b = s_r.sy_a;
		s_nxt.sy_c = s_r.sy_b;
		s_nxt.lv   = agree(s_r.sy_b, s_r.sy_c, s_r.lv);
		case (s_r.st)
			hbs_pkg::ST_OFF: begin
				if (start_cond) begin
					s_nxt.st = hbs_pkg::ST_SETTLE;
				end
			end
			hbs_pkg::ST_SETTLE: begin
				if (s_r.lv[`HBS_SY_CORE] && s_r.lv[`HBS_SY_IO]) begin
					s_nxt.st       = hbs_pkg::ST_CFG;
					s_nxt.cfg_i    = 2'h0;
					s_nxt.cfg_wait = 1'b0;
				end
			end
			hbs_pkg::ST_CFG: begin
				if (!s_r.cfg_wait) begin
					s_nxt.cfg_wait = 1'b1;
				end else if (mem_vld) begin
					s_nxt.cfg_wait = 1'b0;
					s_nxt.cfg_i    = s_r.cfg_i + 2'h1;
					case (s_r.cfg_i)
						2'h0: s_nxt.trim = mem_dat;
						2'h1: s_nxt.pkg = mem_dat;
						default: s_nxt.msize = mem_dat;
					endcase
					if (s_r.cfg_i == 2'(`HBS_CFG_N - 1)) begin
						s_nxt.st = hbs_pkg::ST_CORES;
					end
				end
			end
			hbs_pkg::ST_CORES: begin
				s_nxt.st = hbs_pkg::ST_XTAL;
			end
			hbs_pkg::ST_XTAL: begin
				if (s_r.lv[`HBS_SY_XTAL]) begin
					s_nxt.st = hbs_pkg::ST_RUN;
				end
			end
			hbs_pkg::ST_RUN: begin
				s_nxt.st = hbs_pkg::ST_RUN;
			end
			default: begin
				s_nxt.st = hbs_pkg::ST_OFF;
			end
		endcase
		// state lost
		// Losing both enable and wake, or the hibernation drop itself, wipes the sequence.
		if (!tmr_pwr || (s_r.st != hbs_pkg::ST_OFF && !start_cond)) begin
			s_nxt.st    = hbs_pkg::ST_OFF;
			s_nxt.trim  = 8'h00;
			s_nxt.pkg   = 8'h00;
			s_nxt.msize = 8'h00;
		end
	end

	// State register.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Wake countdown; its state is kept apart from the rest of the sequence.
	hbs_wake_timer u_timer (
		.clock    (clock),
		.resetn   (resetn),
		.slow_tick(slow_tick),
		.start    (tmr_start),
		.count    (hib_wake_count),
		.busy     (tmr_busy),
		.power_en (tmr_pwr)
	);

	hbs_otp_mem #(.DEPTH(`HBS_OTP_BYTES)) u_otp (
		.clock   (clock),
		.resetn  (resetn),
		.rd_en   (mem_rd),
		.wr_en   (mem_wr),
		.addr    (mem_addr),
		.wdata   (otp_wdata),
		.rdata   (mem_dat),
		.rd_valid(mem_vld)
	);

	// Core, crystal and boot outputs decode the registered step.
	assign hib_busy             = tmr_busy;
	assign hib_power_enable_out = tmr_pwr;
	assign otp_ready            = (s_r.st == hbs_pkg::ST_RUN);
	assign otp_rdata            = mem_dat;
	assign otp_rd_valid         = mem_vld & (s_r.st == hbs_pkg::ST_RUN);
	assign pmu_trim             = s_r.trim;
	assign package_sel          = s_r.pkg;
	assign mem_size_sel         = s_r.msize;
	assign app_core_power_en    = (s_r.st == hbs_pkg::ST_CORES) |
	                              (s_r.st == hbs_pkg::ST_XTAL) |
	                              (s_r.st == hbs_pkg::ST_RUN);
	assign wlan_core_power_en   = app_core_power_en;
	assign xtal_power_en        = (s_r.st == hbs_pkg::ST_XTAL) |
	                              (s_r.st == hbs_pkg::ST_RUN);
	assign app_cpu_run          = (s_r.st == hbs_pkg::ST_RUN);
	assign wlan_cpu_run         = app_cpu_run;

	chk_start_cause: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_OFF) && (s_nxt.st == hbs_pkg::ST_SETTLE) |->
		(s_r.lv[`HBS_SY_REGON] || s_r.lv[`HBS_SY_WAKE]))
		else $error("bring-up started without enable or wake");
	chk_cfg_stable: assert property (@(posedge clock) disable iff (!resetn)
		$rose(s_r.st == hbs_pkg::ST_CFG) |->
		$past(s_r.lv[`HBS_SY_CORE]) && $past(s_r.lv[`HBS_SY_IO]))
		else $error("configuration before regulators stable");
	chk_core_order: assert property (@(posedge clock) disable iff (!resetn)
		$rose(xtal_power_en) |-> $past(app_cpu_run == 1'b0) && $past(app_core_power_en))
		else $error("crystal powered before cores");
	chk_boot_order: assert property (@(posedge clock) disable iff (!resetn)
		$rose(app_cpu_run) |-> $past(xtal_power_en) && wlan_cpu_run)
		else $error("processors released out of order");
	chk_cfg_load: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_CFG) && s_r.cfg_wait && mem_vld && (s_r.cfg_i == 2'h0)
		|=> pmu_trim == $past(mem_dat))
		else $error("trim byte not applied");
	chk_hib_wipe: assert property (@(posedge clock) disable iff (!resetn)
		!tmr_pwr |=> !app_cpu_run && !app_core_power_en && (pmu_trim == 8'h00))
		else $error("state kept through hibernation");
	chk_busy_ignore: assert property (@(posedge clock) disable iff (!resetn)
		tmr_busy |-> !tmr_start)
		else $error("request accepted while countdown busy");

	chk_hib_run_only: assert property (@(posedge clock) disable iff (!resetn)
		tmr_start |-> (s_r.st == hbs_pkg::ST_RUN))
		else $error("hibernation request taken outside run step");

	chk_settle_hold: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_SETTLE) && start_cond &&
		!(s_r.lv[`HBS_SY_CORE] && s_r.lv[`HBS_SY_IO]) |=> (s_r.st == hbs_pkg::ST_SETTLE))
		else $error("settle step left before regulators stable");

	chk_pkg_load: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_CFG) && s_r.cfg_wait && mem_vld && (s_r.cfg_i == 2'h1) &&
		start_cond |=> package_sel == $past(mem_dat))
		else $error("package byte not applied");

	chk_msize_load: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_CFG) && s_r.cfg_wait && mem_vld && (s_r.cfg_i == 2'h2) &&
		start_cond |=> (mem_size_sel == $past(mem_dat)) && app_core_power_en)
		else $error("memory size byte not applied");

	chk_xtal_next: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_CORES) && start_cond |=> xtal_power_en && app_core_power_en)
		else $error("crystal not powered after cores");

	chk_boot_wait: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_XTAL) && !s_r.lv[`HBS_SY_XTAL] |=> !app_cpu_run)
		else $error("processors released before crystal running");

	chk_read_answer: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_RUN) && otp_rd_req |=> mem_vld)
		else $error("fuse read not answered");

	chk_prog_gate: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st != hbs_pkg::ST_RUN) |-> !mem_wr)
		else $error("fuse programmed outside run step");

	chk_off_clear: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_OFF) |-> (pmu_trim == 8'h00) && (package_sel == 8'h00) &&
		(mem_size_sel == 8'h00))
		else $error("configuration kept while off");

	chk_off_stay: assert property (@(posedge clock) disable iff (!resetn)
		(s_r.st == hbs_pkg::ST_OFF) && !start_cond |=> (s_r.st == hbs_pkg::ST_OFF))
		else $error("bring-up left off without trigger");
endmodule // hbs_sequencer

/* File: design/hbs_wake_timer.sv */
// Hibernation wake-count timer stepped by slow-clock ticks.
`timescale 1ns/100ps
`include "hbs_map.svh"
module hbs_wake_timer (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   slow_tick,
	input  wire logic                   start,
	input  wire logic [`HBS_WAKE_W-1:0] count,
	output logic                        busy,
	output logic                        power_en
);
	hbs_pkg::hbs_tmr_s t_r;
	hbs_pkg::hbs_tmr_s t_nxt;

	// sync and ignore
	// A request only waits here; it enters the count on the next slow tick.
	// Starts while pending or counting are dropped.
	always_comb begin
		t_nxt = t_r;
		if (start && !t_r.pend && !t_r.run) begin
			t_nxt.pend = 1'b1;
			t_nxt.load = count;
		end
		if (slow_tick) begin
			if (t_r.pend) begin
				t_nxt.pend = 1'b0;
				t_nxt.run  = (t_r.load != '0);
				t_nxt.cnt  = t_r.load;
			end else if (t_r.run) begin
				t_nxt.cnt = t_r.cnt - 1'b1;
				t_nxt.run = (t_r.cnt != `HBS_WAKE_W'(1));
			end
		end
	end

	// State register; unlike the sequence step, this lives through hibernation.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			t_r <= '0;
		end else begin
			t_r <= t_nxt;
		end
	end

	assign busy     = t_r.pend | t_r.run;
	assign power_en = !t_r.run;

	chk_low_span: assert property (@(posedge clock) disable iff (!resetn)
		slow_tick && t_r.run && (t_r.cnt > `HBS_WAKE_W'(1)) |=> !power_en)
		else $error("enable rose before count ended");
	chk_high_end: assert property (@(posedge clock) disable iff (!resetn)
		slow_tick && t_r.run && (t_r.cnt == `HBS_WAKE_W'(1)) |=> power_en)
		else $error("enable not restored at count end");
	chk_tick_start: assert property (@(posedge clock) disable iff (!resetn)
		$rose(t_r.run) |-> $past(slow_tick) && $past(t_r.pend))
		else $error("countdown began off a slow tick");
endmodule // hbs_wake_timer

/* File: testbench/hbs_board_model.sv */
// Board regulators, crystal and slow clock around the sequencer.
`timescale 1ns/100ps
module hbs_board_model #(
	parameter int SLOW_HALF = 156,
	parameter int SETTLE    = 5
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic board_on,
	input  wire logic hib_wake_in,
	input  wire logic hib_power_enable_out,
	input  wire logic xtal_power_en,
	output logic      reg_on_in,
	output logic      slow_clk_in,
	output logic      core_regulator_ok,
	output logic      io_regulator_ok,
	output logic      xtal_ok
);
	logic [8:0] sdiv;
	logic [3:0] rcnt;
	logic [3:0] xcnt;
	logic       pwr;

	// the enable output feeds the regulator enable pin on the board.
	assign reg_on_in = board_on & hib_power_enable_out;
	assign pwr       = reg_on_in | hib_wake_in;

	// regulators settle at different times and fail at once on power loss.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sdiv <= '0;
			slow_clk_in <= 1'b0;
			rcnt <= '0;
			xcnt <= '0;
		end else begin
			sdiv <= (sdiv == SLOW_HALF - 1) ? '0 : sdiv + 9'h001;
			if (sdiv == SLOW_HALF - 1) slow_clk_in <= !slow_clk_in;
			rcnt <= !pwr ? '0 : (rcnt == 4'hf) ? rcnt : rcnt + 4'h1;
			xcnt <= !xtal_power_en ? '0 : (xcnt == 4'hf) ? xcnt : xcnt + 4'h1;
		end
	end

	// The crystal needs a few cycles to run before it reports good.
	assign core_regulator_ok = pwr && (rcnt >= SETTLE);
	assign io_regulator_ok   = pwr && (rcnt >= SETTLE + 2);
	assign xtal_ok           = xtal_power_en && (xcnt >= SETTLE);
endmodule // hbs_board_model

/* File: testbench/hibernation_boot_sequencer_bench.sv */
// Self-checking bench for the hibernation and boot sequencer.
`timescale 1ns/100ps
`include "hbs_map.svh"
module hibernation_boot_sequencer_bench;
	typedef struct {logic [9:0] a; logic [7:0] w; logic [7:0] e;} hbs_row_s;
	logic clock = 1'b0, resetn = 1'b0, board_on = 1'b0, hib_wake_in = 1'b0;
	logic hib_request = 1'b0, otp_rd_req = 1'b0, otp_wr_req = 1'b0;
	logic [15:0] hib_wake_count = 16'h0000;
	logic [9:0] otp_addr = 10'h000;
	logic [7:0] otp_wdata = 8'h00, otp_rdata, pmu_trim, package_sel, mem_size_sel;
	logic reg_on_in, slow_clk_in, core_regulator_ok, io_regulator_ok, xtal_ok;
	logic hib_busy, hib_power_enable_out, otp_ready, otp_rd_valid, xtal_power_en;
	logic app_core_power_en, wlan_core_power_en, app_cpu_run, wlan_cpu_run;
	logic pc = 1'b0, px = 1'b0, pr = 1'b0, ps = 1'b0, pe = 1'b1;
	int bad_count = 0, compares = 0, order_bad = 0, low_ticks = 0, drops = 0, cyc = 0;
	hbs_row_s rows [7] = '{'{10'h000, 8'h00, 8'h00}, '{10'h000, 8'h0f, 8'h0f},
		'{10'h000, 8'hf0, 8'hff}, '{10'h000, 8'h00, 8'hff}, '{10'h001, 8'ha5, 8'ha5},
		'{10'h2ff, 8'h81, 8'h81}, '{10'h300, 8'hff, 8'h00}};

	hbs_sequencer DUT (.clock(clock), .resetn(resetn), .slow_clk_in(slow_clk_in),
		.reg_on_in(reg_on_in), .hib_wake_in(hib_wake_in),
		.core_regulator_ok(core_regulator_ok), .io_regulator_ok(io_regulator_ok),
		.xtal_ok(xtal_ok), .hib_request(hib_request), .hib_wake_count(hib_wake_count),
		.hib_busy(hib_busy), .hib_power_enable_out(hib_power_enable_out),
		.otp_rd_req(otp_rd_req), .otp_wr_req(otp_wr_req), .otp_addr(otp_addr),
		.otp_wdata(otp_wdata), .otp_ready(otp_ready), .otp_rdata(otp_rdata),
		.otp_rd_valid(otp_rd_valid), .pmu_trim(pmu_trim), .package_sel(package_sel),
		.mem_size_sel(mem_size_sel), .app_core_power_en(app_core_power_en),
		.wlan_core_power_en(wlan_core_power_en), .xtal_power_en(xtal_power_en),
		.app_cpu_run(app_cpu_run), .wlan_cpu_run(wlan_cpu_run));

	hbs_board_model board (.clock(clock), .resetn(resetn), .board_on(board_on),
		.hib_wake_in(hib_wake_in), .hib_power_enable_out(hib_power_enable_out),
		.xtal_power_en(xtal_power_en), .reg_on_in(reg_on_in), .slow_clk_in(slow_clk_in),
		.core_regulator_ok(core_regulator_ok), .io_regulator_ok(io_regulator_ok),
		.xtal_ok(xtal_ok));

	// The clock toggles every half period of 50 ns, a period of 100 ns.
	always #50 clock = ~clock;

	// Watches step order, slow ticks while powered down and the cycle ceiling.
	always @(posedge clock) begin
		if (app_core_power_en && !pc && !(core_regulator_ok && io_regulator_ok)) order_bad++;
		if (xtal_power_en && !px && !app_core_power_en) order_bad++;
		if (app_cpu_run && !pr && !xtal_ok) order_bad++;
		if (wlan_cpu_run !== app_cpu_run || wlan_core_power_en !== app_core_power_en)
			order_bad++;
		if (slow_clk_in && !ps && !hib_power_enable_out) low_ticks++;
		if (!hib_power_enable_out && pe) drops++;
		{pc, px, pr, ps, pe} = {app_core_power_en, xtal_power_en, app_cpu_run,
			slow_clk_in, hib_power_enable_out};
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic pick(input int k);
		pick = (k == 0) ? app_cpu_run : hib_power_enable_out;
	endfunction

	// Bounded wait for a level on a watched output.
	task automatic wait_for(input int k, input logic v, input int lim);
		// Polled on the falling edge so that outputs launched at the rising edge have settled.
		for (int i = 0; i < lim && pick(k) !== v; i++) @(negedge clock);
		@(negedge clock);
		chk(k == 0 ? "app_cpu_run" : "hib_power_enable_out", pick(k), v);
	endtask

	// Program a byte, then read it back on the next cycle.
	task automatic fuse(input logic [9:0] a, input logic [7:0] w, input logic [7:0] e);
		@(posedge clock);
		otp_addr <= a;
		otp_wdata <= w;
		otp_wr_req <= 1'b1;
		@(posedge clock);
		otp_wr_req <= 1'b0;
		otp_rd_req <= 1'b1;
		@(posedge clock);
		otp_rd_req <= 1'b0;
		@(negedge clock);
		chk("otp_rd_valid", otp_rd_valid, 1);
		chk("otp_rdata", otp_rdata, e);
	endtask

	// the count is presented with the request itself.
	task automatic hib_req(input logic [15:0] n, input logic busy);
		@(posedge clock);
		hib_wake_count <= n;
		hib_request <= 1'b1;
		@(posedge clock);
		hib_request <= 1'b0;
		@(negedge clock);
		chk("hib_busy", hib_busy, busy);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence: reset, fuse table, then the awkward power cases.
	initial begin
		repeat (10) @(posedge clock);
		chk("hib_power_enable_out", hib_power_enable_out, 1);
		chk("app_cpu_run", app_cpu_run, 0);
		resetn <= 1'b1;
		board_on <= 1'b1;
		wait_for(0, 1'b1, 300);
		chk("pmu_trim", pmu_trim, 8'h00);
		$display("test reset and bring-up done");
		foreach (rows[i]) fuse(rows[i].a, rows[i].w, rows[i].e);
		fuse(10'h002, 8'h3c, 8'h3c);
		$display("test fuse table done");
		@(posedge clock);
		board_on <= 1'b0;
		wait_for(0, 1'b0, 100);
		hib_req(16'h0002, 1'b0);
		@(posedge clock);
		hib_wake_in <= 1'b1;
		wait_for(0, 1'b1, 300);
		chk("pmu_trim", pmu_trim, 8'hff);
		chk("package_sel", package_sel, 8'ha5);
		chk("mem_size_sel", mem_size_sel, 8'h3c);
		@(posedge clock);
		hib_wake_in <= 1'b0;
		board_on <= 1'b1;
		repeat (20) @(posedge clock);
		$display("test wake input bring-up done");
		hib_req(16'h0000, 1'b1);
		repeat (800) @(posedge clock);
		chk("drops", drops, 0);
		low_ticks = 0;
		hib_req(16'h0003, 1'b1);
		hib_req(16'h0001, 1'b1);
		wait_for(1, 1'b0, 700);
		wait_for(1, 1'b1, 1500);
		chk("low_ticks", low_ticks, 3);
		chk("drops", drops, 1);
		wait_for(0, 1'b1, 300);
		chk("order_bad", order_bad, 0);
		$display("test hibernation done");
		tally_and_finish();
	end
endmodule // hibernation_boot_sequencer_bench
